// [rtl/tvr_regbank.sv]
`timescale 1ns/100ps
module tvr_regbank #(
	parameter logic [7:0] FW_REVISION = 8'h12, // Arbitrary value
	parameter int FLASH_HALF = tvr_pkg::FLASH_HALF_CYC
) (
	input wire logic ref_clk_i, // System clock
	input wire logic nrst_i, // Async reset, active low
	input wire tvr_pkg::tvr_req_t req_i, // Register request
	output logic [31:0] rdata_o, // Read data
	output logic ack_o, // Access answered
	output logic busy_o, // Access in progress
	input wire logic trg_match_i, // Trigger matching mode
	input wire logic test_mode_i, // Buffer test mode
	input wire logic comp_rd_en_i, // Table read enable
	input wire logic evf_en_i, // Event FIFO enable
	input wire logic irq_en_i, // Interrupts enabled
	input wire logic ext_trig_i, // External trigger pulse
	input wire logic tdc_error_i, // Converter error
	input wire logic [15:0] buf_words_i, // Buffer word count
	input wire logic [15:0] buf_events_i, // Buffer event count
	input wire logic buf_dready_i, // Buffer has data
	input wire logic evt_done_i, // Event written pulse
	input wire logic [15:0] evt_words_i, // Words of that event
	input wire logic mcu_read_ok_i, // Opcode readable
	input wire logic mcu_write_ok_i, // Opcode writable
	input wire logic [15:0] mcu_rdata_i, // Opcode from micro
	output logic mcu_wr_o, // Opcode write pulse
	output logic mcu_rd_o, // Opcode read pulse
	output logic [15:0] mcu_wdata_o, // Opcode to micro
	output logic module_reset_o, // Module reset pulse
	output logic tdc_clear_o, // Converter clear pulse
	output logic buf_clear_o, // Buffer flush pulse
	output logic tdc_global_reset_o, // Global reset pulse
	output logic tdc_event_reset_o, // Event reset pulse
	output logic trigger_o, // Trigger pulse
	output logic tst_push_o, // Test word push pulse
	output logic [31:0] tst_word_o, // Test word
	output logic tdc_block_o, // Converter data blocked
	output tvr_pkg::tvr_flags_t flags_o, // Status flags
	output logic irq_o, // Interrupt request
	output logic prog_out_o, // Programmable output
	output logic [7:0] mcst_base_o, // Multicast base
	output logic [7:0] chain_ctrl_o, // Chain control
	output logic [7:0] blt_count_o, // Events per block
	output logic blt_aligned_o, // Aligned transfer on
	output logic flash_cs_n_o, // Flash select, low
	output logic flash_sck_o, // Flash serial clock
	output logic flash_mosi_o, // Flash serial out
	input wire logic flash_miso_i, // Flash serial in
	output logic [15:0] comp_addr_o, // Table word address
	output logic comp_rd_o, // Table read pulse
	input wire logic [15:0] comp_data_i // Table data, next cycle
);

	// ------------------------------------------------------------
	// Declarations and decode
	// ------------------------------------------------------------
	localparam int EVF_AW = $clog2(tvr_pkg::EVF_DEPTH);

	tvr_pkg::tvr_state_t st_reg;
	tvr_pkg::tvr_flags_t flags_next;
	logic [31:0] evcnt_reg;
	logic [15:0] afl_reg;
	logic [1:0] out_sel_reg;
	logic [7:0] page_reg;
	logic [31:0] scr32_reg;
	logic [15:0] scr16_reg;
	logic [31:0] evf_mem [tvr_pkg::EVF_DEPTH];
	logic [EVF_AW-1:0] evf_wp_reg;
	logic [EVF_AW-1:0] evf_rp_reg;
	logic [EVF_AW:0] evf_cnt_reg;
	logic [7:0] fl_sh_reg;
	logic [3:0] fl_bits_reg;
	logic [7:0] fl_half_reg;
	logic idle, wr_go, rd_go, acc_go, clr_evt, wipe, trig_any;
	logic evf_full, evf_push, evf_pop, fl_go, fl_tick, fl_done;
	logic comp_hit, buf_full;
	tvr_pkg::tvr_evword_t evf_word;

	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic pick(input logic [1:0] sel,
		input tvr_pkg::tvr_flags_t f);
		case (sel)
			tvr_pkg::OSEL_DREADY: pick = f.dready;
			tvr_pkg::OSEL_FULL: pick = f.full;
			tvr_pkg::OSEL_ALMOST: pick = f.almost;
			default: pick = f.error;
		endcase
	endfunction

	// Requests are only taken while idle; busy_o tells the master
	assign idle = (st_reg == tvr_pkg::ST_IDLE);
	assign wr_go = idle & req_i.wr;
	assign rd_go = idle & req_i.rd & ~req_i.wr;
	assign acc_go = wr_go | rd_go;
	assign clr_evt = wr_go & hit(req_i.addr, tvr_pkg::OFS_SW_CLEAR);
	// Software reset also empties what the block itself counts
	assign wipe = clr_evt | (acc_go & hit(req_i.addr,
		tvr_pkg::OFS_MOD_RESET));
	assign trig_any = ext_trig_i |
		(wr_go & hit(req_i.addr, tvr_pkg::OFS_SW_TRIG));
	assign comp_hit = (req_i.addr >= tvr_pkg::OFS_COMP_LO) &&
		(req_i.addr <= tvr_pkg::OFS_COMP_HI) && !req_i.addr[0];
	assign fl_go = acc_go & hit(req_i.addr, tvr_pkg::OFS_FLASH_DATA);
	assign evf_full = (evf_cnt_reg ==
		(EVF_AW+1)'(tvr_pkg::EVF_DEPTH));
	assign evf_push = evf_en_i & evt_done_i & ~evf_full;
	assign evf_pop = rd_go & hit(req_i.addr, tvr_pkg::OFS_EVF_DATA) &
		(evf_cnt_reg != '0);
	assign evf_word.evcnt = evcnt_reg[15:0];
	assign evf_word.nwords = evt_words_i;
	assign fl_tick = (fl_half_reg == 8'(FLASH_HALF - 1));
	assign fl_done = (st_reg == tvr_pkg::ST_FLASH) & fl_tick &
		flash_sck_o & (fl_bits_reg == 4'h0);
	assign buf_full = (buf_words_i >= tvr_pkg::BUF_FULL_LEVEL);

	// Status flags as the buffer, FIFO and converter stand now
	always_comb
	begin
		flags_next.dready = buf_dready_i;
		flags_next.full = buf_full | (evf_en_i & evf_full);
		flags_next.almost = (buf_words_i >= afl_reg);
		flags_next.error = tdc_error_i;
	end

	// ------------------------------------------------------------
	// Bus sequencing and read data
	// ------------------------------------------------------------
	// Table reads with comp_rd_en_i set and all flash data accesses take extra cycles; others answer next edge
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_reg <= tvr_pkg::ST_IDLE;
			rdata_o <= 32'h0;
			ack_o <= 1'b0;
			busy_o <= 1'b0;
			comp_rd_o <= 1'b0;
			comp_addr_o <= 16'h0;
			mcu_rd_o <= 1'b0;
		end
		else
		begin
			ack_o <= 1'b0;
			comp_rd_o <= 1'b0;
			mcu_rd_o <= 1'b0;
			case (st_reg)
				tvr_pkg::ST_IDLE:
				begin
					if (fl_go)
					begin
						st_reg <= tvr_pkg::ST_FLASH;
						busy_o <= 1'b1;
					end
					else if (rd_go && comp_hit && comp_rd_en_i)
					begin
						st_reg <= tvr_pkg::ST_SRAM_ADDR;
						busy_o <= 1'b1;
						comp_rd_o <= 1'b1;
						comp_addr_o <= {page_reg, req_i.addr[8:1]};
					end
					else if (acc_go)
					begin
						ack_o <= 1'b1;
						rdata_o <= 32'h0;
						if (!rd_go)
							rdata_o <= 32'h0;
						else if (hit(req_i.addr, tvr_pkg::OFS_MCST_BASE))
							rdata_o <= {24'h0, mcst_base_o};
						else if (hit(req_i.addr, tvr_pkg::OFS_CHAIN_CTRL))
							rdata_o <= {24'h0, chain_ctrl_o};
						else if (hit(req_i.addr, tvr_pkg::OFS_EV_COUNT))
							rdata_o <= evcnt_reg;
						else if (hit(req_i.addr, tvr_pkg::OFS_EV_STORED))
							rdata_o <= {16'h0, buf_events_i};
						else if (hit(req_i.addr, tvr_pkg::OFS_AFL))
							rdata_o <= {16'h0, afl_reg};
						else if (hit(req_i.addr, tvr_pkg::OFS_BLT_NUM))
							rdata_o <= {24'h0, blt_count_o};
						else if (hit(req_i.addr, tvr_pkg::OFS_FW_REV))
							rdata_o <= {24'h0, FW_REVISION};
						else if (hit(req_i.addr, tvr_pkg::OFS_TEST_WORD))
							rdata_o <= tst_word_o;
						else if (hit(req_i.addr, tvr_pkg::OFS_OUT_SEL))
							rdata_o <= {30'h0, out_sel_reg};
						else if (hit(req_i.addr, tvr_pkg::OFS_MICRO))
						begin
							// Reads before read-ok return zero, no pop
							if (mcu_read_ok_i)
							begin
								rdata_o <= {16'h0, mcu_rdata_i};
								mcu_rd_o <= 1'b1;
							end
						end
						else if (hit(req_i.addr, tvr_pkg::OFS_HANDSHAKE))
						begin
							rdata_o[tvr_pkg::HS_READ_OK_BIT] <=
								mcu_read_ok_i;
							rdata_o[tvr_pkg::HS_WRITE_OK_BIT] <=
								mcu_write_ok_i;
						end
						else if (hit(req_i.addr, tvr_pkg::OFS_FLASH_SEL))
							rdata_o <= {31'h0, flash_cs_n_o};
						else if (hit(req_i.addr, tvr_pkg::OFS_COMP_PAGE))
							rdata_o <= {24'h0, page_reg};
						else if (hit(req_i.addr, tvr_pkg::OFS_EVF_DATA))
						begin
							if (evf_pop)
								rdata_o <= evf_mem[evf_rp_reg];
						end
						else if (hit(req_i.addr, tvr_pkg::OFS_EVF_COUNT))
							rdata_o <= 32'(evf_cnt_reg);
						else if (hit(req_i.addr, tvr_pkg::OFS_EVF_STATUS))
						begin
							rdata_o[tvr_pkg::EVF_DREADY_BIT] <=
								(evf_cnt_reg != '0);
							rdata_o[tvr_pkg::EVF_FULL_BIT] <= evf_full;
						end
						else if (hit(req_i.addr, tvr_pkg::OFS_SCRATCH32))
							rdata_o <= scr32_reg;
						else if (hit(req_i.addr, tvr_pkg::OFS_SCRATCH16))
							rdata_o <= {16'h0, scr16_reg};
					end
				end
				tvr_pkg::ST_SRAM_ADDR:
					st_reg <= tvr_pkg::ST_SRAM_DATA;
				tvr_pkg::ST_SRAM_DATA:
				begin
					rdata_o <= {16'h0, comp_data_i};
					ack_o <= 1'b1;
					busy_o <= 1'b0;
					st_reg <= tvr_pkg::ST_IDLE;
				end
				default:
				begin
					if (fl_done)
					begin
						rdata_o <= {24'h0, fl_sh_reg};
						ack_o <= 1'b1;
						busy_o <= 1'b0;
						st_reg <= tvr_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Software-written settings
	// ------------------------------------------------------------
	// Configuration survives a software reset; only hardware reset loads it
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mcst_base_o <= tvr_pkg::RST_MCST_BASE;
			chain_ctrl_o <= tvr_pkg::RST_CHAIN_CTRL;
			afl_reg <= tvr_pkg::RST_AFL;
			blt_count_o <= tvr_pkg::RST_BLT_NUM;
			blt_aligned_o <= 1'b0;
			out_sel_reg <= tvr_pkg::OSEL_DREADY;
			page_reg <= tvr_pkg::RST_COMP_PAGE;
			flash_cs_n_o <= tvr_pkg::RST_FLASH_CS_N;
			scr32_reg <= 32'h0;
			scr16_reg <= 16'h0;
			tst_word_o <= 32'h0;
			mcu_wdata_o <= 16'h0;
		end
		else if (wr_go)
		begin
			if (hit(req_i.addr, tvr_pkg::OFS_MCST_BASE))
				mcst_base_o <= req_i.wdata[7:0];
			else if (hit(req_i.addr, tvr_pkg::OFS_CHAIN_CTRL))
				chain_ctrl_o <= req_i.wdata[7:0];
			else if (hit(req_i.addr, tvr_pkg::OFS_AFL))
			begin
				// Out-of-range levels are dropped, old level kept
				if (req_i.wdata[15:0] <= tvr_pkg::AFL_MAX)
					afl_reg <= req_i.wdata[15:0];
			end
			else if (hit(req_i.addr, tvr_pkg::OFS_BLT_NUM))
			begin
				blt_count_o <= req_i.wdata[7:0];
				blt_aligned_o <= (req_i.wdata[7:0] != 8'h00);
			end
			else if (hit(req_i.addr, tvr_pkg::OFS_TEST_WORD))
				tst_word_o <= req_i.wdata;
			else if (hit(req_i.addr, tvr_pkg::OFS_OUT_SEL))
				out_sel_reg <= req_i.wdata[1:0];
			else if (hit(req_i.addr, tvr_pkg::OFS_MICRO))
			begin
				if (mcu_write_ok_i)
					mcu_wdata_o <= req_i.wdata[15:0];
			end
			else if (hit(req_i.addr, tvr_pkg::OFS_FLASH_SEL))
				flash_cs_n_o <= req_i.wdata[0];
			else if (hit(req_i.addr, tvr_pkg::OFS_COMP_PAGE))
				page_reg <= req_i.wdata[7:0];
			else if (hit(req_i.addr, tvr_pkg::OFS_SCRATCH32))
				scr32_reg <= req_i.wdata;
			else if (hit(req_i.addr, tvr_pkg::OFS_SCRATCH16))
				scr16_reg <= req_i.wdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// Strobes and the block level to the rest of the module
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			module_reset_o <= 1'b0;
			tdc_clear_o <= 1'b0;
			buf_clear_o <= 1'b0;
			tdc_global_reset_o <= 1'b0;
			tdc_event_reset_o <= 1'b0;
			trigger_o <= 1'b0;
			tst_push_o <= 1'b0;
			mcu_wr_o <= 1'b0;
			tdc_block_o <= 1'b0;
		end
		else
		begin
			// Data value is ignored; any access makes one pulse
			module_reset_o <= acc_go &
				hit(req_i.addr, tvr_pkg::OFS_MOD_RESET);
			tdc_clear_o <= clr_evt;
			buf_clear_o <= clr_evt;
			tdc_global_reset_o <= clr_evt;
			tdc_event_reset_o <= wr_go &
				hit(req_i.addr, tvr_pkg::OFS_EV_RESET);
			trigger_o <= trig_any;
			tst_push_o <= wr_go & test_mode_i &
				hit(req_i.addr, tvr_pkg::OFS_TEST_WORD);
			tdc_block_o <= test_mode_i;
			mcu_wr_o <= wr_go & mcu_write_ok_i &
				hit(req_i.addr, tvr_pkg::OFS_MICRO);
		end
	end

	// ------------------------------------------------------------
	// Event counter and status flags
	// ------------------------------------------------------------
	// Clear beats a trigger arriving in the same cycle
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			evcnt_reg <= 32'h0;
		else if (wipe)
			evcnt_reg <= 32'h0;
		else if (trig_any && trg_match_i)
			evcnt_reg <= evcnt_reg + 32'h1;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			flags_o <= '0;
			irq_o <= 1'b0;
			prog_out_o <= 1'b0;
		end
		else
		begin
			flags_o <= flags_next;
			irq_o <= irq_en_i & flags_next.almost;
			prog_out_o <= pick(out_sel_reg, flags_next);
		end
	end

	// ------------------------------------------------------------
	// Event descriptor FIFO
	// ------------------------------------------------------------
	// Pushes while full are lost; the full flag warns software first
	always_ff @(posedge ref_clk_i)
	begin
		if (evf_push)
			evf_mem[evf_wp_reg] <= evf_word;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			evf_wp_reg <= '0;
			evf_rp_reg <= '0;
			evf_cnt_reg <= '0;
		end
		else if (wipe)
		begin
			evf_wp_reg <= '0;
			evf_rp_reg <= '0;
			evf_cnt_reg <= '0;
		end
		else
		begin
			if (evf_push)
				evf_wp_reg <= evf_wp_reg + 1'b1;
			if (evf_pop)
				evf_rp_reg <= evf_rp_reg + 1'b1;
			if (evf_push && !evf_pop)
				evf_cnt_reg <= evf_cnt_reg + 1'b1;
			else if (evf_pop && !evf_push)
				evf_cnt_reg <= evf_cnt_reg - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Serial flash byte engine
	// ------------------------------------------------------------
	// Mode 0 shifter, MSB first; a read shifts out ones as filler
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			fl_sh_reg <= 8'h0;
			fl_bits_reg <= 4'h0;
			fl_half_reg <= 8'h0;
			flash_sck_o <= 1'b0;
			flash_mosi_o <= 1'b0;
		end
		else if (fl_go)
		begin
			fl_sh_reg <= wr_go ? req_i.wdata[7:0] : 8'hff;
			flash_mosi_o <= wr_go ? req_i.wdata[7] : 1'b1;
			fl_bits_reg <= 4'(tvr_pkg::FLASH_BITS);
			fl_half_reg <= 8'h0;
			flash_sck_o <= 1'b0;
		end
		else if (st_reg == tvr_pkg::ST_FLASH)
		begin
			fl_half_reg <= fl_tick ? 8'h0 : fl_half_reg + 8'h1;
			if (fl_tick && !flash_sck_o)
			begin
				flash_sck_o <= 1'b1;
				fl_sh_reg <= {fl_sh_reg[6:0], flash_miso_i};
				fl_bits_reg <= fl_bits_reg - 4'h1;
			end
			else if (fl_tick)
			begin
				flash_sck_o <= 1'b0;
				flash_mosi_o <= fl_sh_reg[7];
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic seen_reg;
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			seen_reg <= 1'b0;
		else
			seen_reg <= 1'b1;
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	a_mcst_reset_value: assert property (
		!seen_reg |-> mcst_base_o == tvr_pkg::RST_MCST_BASE)
		else $error("multicast base not at reset value");
	a_reset_one_pulse: assert property (
		acc_go && hit(req_i.addr, tvr_pkg::OFS_MOD_RESET)
		|=> module_reset_o ##1 !module_reset_o)
		else $error("module reset not a single pulse");
	a_clear_effects: assert property (
		clr_evt |=> tdc_clear_o && buf_clear_o && tdc_global_reset_o
		&& evcnt_reg == 32'h0 && evf_cnt_reg == '0)
		else $error("clear did not take full effect");
	a_count_mode: assert property (
		!trg_match_i && !wipe |=> $stable(evcnt_reg))
		else $error("event counter moved outside matching mode");
	a_almost_level: assert property (
		buf_words_i >= afl_reg && irq_en_i |=> flags_o.almost && irq_o)
		else $error("almost-full not flagged");
	a_level_limit: assert property (
		afl_reg <= tvr_pkg::AFL_MAX)
		else $error("almost-full level out of range");
	a_test_push: assert property (
		wr_go && test_mode_i && hit(req_i.addr, tvr_pkg::OFS_TEST_WORD)
		|=> tst_push_o && tst_word_o == $past(req_i.wdata))
		else $error("test word not pushed");
	a_prog_follow: assert property (
		prog_out_o == pick($past(out_sel_reg), flags_o))
		else $error("programmable output mismatch");
	a_micro_gate: assert property (
		mcu_wr_o |-> $past(mcu_write_ok_i))
		else $error("opcode written without write-ok");
	// One byte is sixteen half periods of the serial clock after busy rises
	localparam int FL_ACK_LO = 2 * tvr_pkg::FLASH_BITS * FLASH_HALF - 1;
	localparam int FL_ACK_HI = 2 * tvr_pkg::FLASH_BITS * FLASH_HALF + 1;
	a_flash_byte: assert property (
		fl_go |=> busy_o ##[FL_ACK_LO:FL_ACK_HI] ack_o)
		else $error("flash byte not finished in time");
	a_module_full: assert property (
		evf_en_i && evf_full |=> flags_o.full)
		else $error("module full not raised by FIFO");

	c_sw_trigger: cover property (
		wr_go && hit(req_i.addr, tvr_pkg::OFS_SW_TRIG) && trg_match_i);
	c_flash_read: cover property (rd_go && fl_go ##[1:100] ack_o);
	c_table_read: cover property (comp_rd_o ##2 ack_o);
	c_fifo_pop: cover property (evf_pop);

endmodule

// [rtl/tvr_pkg.sv]
package tvr_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_MCST_BASE = 16'h1010;
	localparam logic [15:0] OFS_CHAIN_CTRL = 16'h1012;
	localparam logic [15:0] OFS_MOD_RESET = 16'h1014;
	localparam logic [15:0] OFS_SW_CLEAR = 16'h1016;
	localparam logic [15:0] OFS_EV_RESET = 16'h1018;
	localparam logic [15:0] OFS_SW_TRIG = 16'h101a;
	localparam logic [15:0] OFS_EV_COUNT = 16'h101c;
	localparam logic [15:0] OFS_EV_STORED = 16'h1020;
	localparam logic [15:0] OFS_AFL = 16'h1022;
	localparam logic [15:0] OFS_BLT_NUM = 16'h1024;
	localparam logic [15:0] OFS_FW_REV = 16'h1026;
	localparam logic [15:0] OFS_TEST_WORD = 16'h1028;
	localparam logic [15:0] OFS_OUT_SEL = 16'h102c;
	localparam logic [15:0] OFS_MICRO = 16'h102e;
	localparam logic [15:0] OFS_HANDSHAKE = 16'h1030;
	localparam logic [15:0] OFS_FLASH_SEL = 16'h1032;
	localparam logic [15:0] OFS_FLASH_DATA = 16'h1034;
	localparam logic [15:0] OFS_COMP_PAGE = 16'h1036;
	localparam logic [15:0] OFS_EVF_DATA = 16'h1038;
	localparam logic [15:0] OFS_EVF_COUNT = 16'h103c;
	localparam logic [15:0] OFS_EVF_STATUS = 16'h103e;
	localparam logic [15:0] OFS_SCRATCH32 = 16'h1200;
	localparam logic [15:0] OFS_SCRATCH16 = 16'h1204;
	localparam logic [15:0] OFS_COMP_LO = 16'h8000;
	localparam logic [15:0] OFS_COMP_HI = 16'h81fe;

	// ------------------------------------------------------------
	// Reset values, limits and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RST_MCST_BASE = 8'haa;
	localparam logic [7:0] RST_CHAIN_CTRL = 8'h00;
	localparam logic [15:0] RST_AFL = 16'h0040;
	localparam logic [7:0] RST_BLT_NUM = 8'h00;
	localparam logic RST_FLASH_CS_N = 1'b1;
	localparam logic [7:0] RST_COMP_PAGE = 8'h00;
	localparam logic [15:0] AFL_MAX = 16'h7fdf;
	localparam int BUF_DEPTH = 32768;
	localparam int BUF_FULL_MARGIN = 33;
	localparam logic [15:0] BUF_FULL_LEVEL =
		16'(BUF_DEPTH - BUF_FULL_MARGIN);
	localparam int EVF_DEPTH = 1024;
	localparam int FLASH_PAGES = 2048;
	localparam int FLASH_PAGE_BYTES = 264;
	localparam int FLASH_USED_BYTES = 256;
	localparam int FLASH_BITS = 8;
	localparam int HS_READ_OK_BIT = 0;
	localparam int HS_WRITE_OK_BIT = 1;
	localparam int EVF_DREADY_BIT = 0;
	localparam int EVF_FULL_BIT = 1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int FLASH_HALF_NS = 40;
	localparam int FLASH_HALF_CYC = (FLASH_HALF_NS / CLK_PERIOD_NS < 1) ?
		1 : FLASH_HALF_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Codes and types
	// ------------------------------------------------------------
	localparam logic [1:0] OSEL_DREADY = 2'h0;
	localparam logic [1:0] OSEL_FULL = 2'h1;
	localparam logic [1:0] OSEL_ALMOST = 2'h2;
	localparam logic [1:0] OSEL_ERROR = 2'h3;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [31:0] wdata;
	} tvr_req_t;

	typedef struct packed {
		logic dready;
		logic full;
		logic almost;
		logic error;
	} tvr_flags_t;

	typedef struct packed {
		logic [15:0] evcnt;
		logic [15:0] nwords;
	} tvr_evword_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SRAM_ADDR,
		ST_SRAM_DATA,
		ST_FLASH
	} tvr_state_t;

endpackage

// [tb/tvr_far_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Table memory and serial flash stand-in
// ----------------------------------------
module tvr_far_model (
	input wire logic ref_clk_i, // Clock
	input wire logic comp_rd_i, // Table read pulse
	input wire logic [15:0] comp_addr_i, // Table address
	output logic [15:0] comp_data_o = 16'h0000, // Table data
	input wire logic cs_n_i, // Flash select, low
	input wire logic sck_i, // Flash clock
	input wire logic mosi_i, // Flash data in
	output logic miso_o, // Flash data
	output logic [7:0] rx_o // Last byte taken in
);
	// Fixed byte the flash answers with, MSB first
	localparam logic [7:0] FLASH_BYTE = 8'ha6;
	logic [2:0] nbit = 3'h0;
	// Data is valid only the cycle after a read; it scrambles otherwise
	always_ff @(posedge ref_clk_i)
	begin
		if (comp_rd_i)
			comp_data_o <= comp_addr_i ^ 16'h5a5a;
		else
			comp_data_o <= ~comp_data_o;
	end
	// Bits are taken on the rising clock; the next one shows at once
	always_ff @(posedge sck_i)
	begin
		rx_o <= {rx_o[6:0], mosi_i};
		nbit <= nbit + 3'h1;
	end
	// Deselected, the line floats: show the inverse of a driven level
	assign miso_o = cs_n_i ? ~FLASH_BYTE[7] : FLASH_BYTE[3'h7 - nbit];
endmodule

// [tb/tdc_vme_control_register_bank_tb.sv]
`timescale 1ns/100ps
module tdc_vme_control_register_bank_tb;
	logic ref_clk_i, nrst_i, ack, irq, csn, sck, crd, mi, mo;
	logic tm = 0, cen = 0, ie = 0, z = 0;
	logic ee = 0, ed = 0, tmd = 0, ok = 0;
	logic [15:0] bw = 0, ca, cd, z16 = 0, ew = 0;
	logic [31:0] rdat, rd;
	logic t, c, b, g, mr, tp, mw, blk;
	logic [7:0] pul, frx;
	tvr_pkg::tvr_req_t req = '0;
	tvr_pkg::tvr_flags_t fl;
	int n_mismatch = 0, check_count = 0;
	tvr_regbank #(.FW_REVISION(8'h3b), .FLASH_HALF(1)) uut (.ref_clk_i,
		.nrst_i, .req_i(req),
		.rdata_o(rdat), .ack_o(ack), .busy_o(), .trg_match_i(tm),
		.test_mode_i(tmd), .comp_rd_en_i(cen), .evf_en_i(ee),
		.irq_en_i(ie),
		.ext_trig_i(z), .tdc_error_i(z), .buf_words_i(bw), .buf_events_i(z16),
		.buf_dready_i(z), .evt_done_i(ed), .evt_words_i(ew),
		.mcu_read_ok_i(ok), .mcu_write_ok_i(ok), .mcu_rdata_i(z16),
		.mcu_wr_o(mw), .mcu_rd_o(), .mcu_wdata_o(), .module_reset_o(mr),
		.tdc_clear_o(c), .buf_clear_o(b), .tdc_global_reset_o(g),
		.tdc_event_reset_o(), .trigger_o(t), .tst_push_o(tp),
		.tst_word_o(),
		.tdc_block_o(blk), .flags_o(fl), .irq_o(irq), .prog_out_o(),
		.mcst_base_o(), .chain_ctrl_o(), .blt_count_o(), .blt_aligned_o(),
		.flash_cs_n_o(csn), .flash_sck_o(sck), .flash_mosi_o(mo),
		.flash_miso_i(mi), .comp_addr_o(ca), .comp_rd_o(crd),
		.comp_data_i(cd));
	tvr_far_model far (.ref_clk_i, .comp_rd_i(crd), .comp_addr_i(ca),
		.comp_data_o(cd), .cs_n_i(csn), .sck_i(sck), .mosi_i(mo),
		.miso_o(mi), .rx_o(frx));
	// ----------------------------------------
	// Bus cycles and comparison
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %0t %h %h", $time, s, e);
		end
	endtask
	// Values are taken at the edge that ends the answer cycle
	task automatic bus(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int n;
		req <= '{rd: !w, wr: w, addr: a, wdata: d};
		@(posedge ref_clk_i);
		req <= '0;
		n = 0;
		while (ack !== 1'b1 && n < 200)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		if (n == 200)
			n_mismatch++;
		rd = rdat;
		pul = {blk, mw, tp, mr, t, c, b, g};
	endtask
	task end_of_test;
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_defaults;
		bus(0, tvr_pkg::OFS_MCST_BASE, 0);
		chk(rd, 32'h000000aa);
		bus(0, tvr_pkg::OFS_AFL, 0);
		chk(rd, 32'h00000040);
		bus(0, tvr_pkg::OFS_BLT_NUM, 0);
		chk(rd, 32'h00000000);
		bus(0, tvr_pkg::OFS_FW_REV, 0);
		chk(rd, 32'h0000003b);
		chk(csn, 1'b1);
	endtask
	task t_scratch;
		bus(1, tvr_pkg::OFS_SCRATCH32, 32'hdeadbeef);
		bus(1, tvr_pkg::OFS_SCRATCH16, 32'h00001234);
		bus(0, tvr_pkg::OFS_SCRATCH32, 0);
		chk(rd, 32'hdeadbeef);
		bus(0, tvr_pkg::OFS_SCRATCH16, 0);
		chk(rd, 32'h00001234);
	endtask
	// Boundary level is kept, one above it is refused
	task t_level;
		bus(1, tvr_pkg::OFS_AFL, 32'h00007fdf);
		bus(1, tvr_pkg::OFS_AFL, 32'h00007fe0);
		bus(0, tvr_pkg::OFS_AFL, 0);
		chk(rd, 32'h00007fdf);
		bus(1, tvr_pkg::OFS_AFL, 32'h00000010);
		bw <= 16'h0010;
		ie <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		chk({fl.almost, irq}, 2'h3);
		bw <= 16'h000f;
		repeat (3) @(posedge ref_clk_i);
		chk({fl.almost, irq}, 2'h0);
	endtask
	task t_trigger;
		tm <= 1'b1;
		bus(1, tvr_pkg::OFS_SW_TRIG, 0);
		chk(pul[3], 1'b1);
		tm <= 1'b0;
		bus(1, tvr_pkg::OFS_SW_TRIG, 0);
		bus(0, tvr_pkg::OFS_EV_COUNT, 0);
		chk(rd, 32'h00000001);
		bus(1, tvr_pkg::OFS_SW_CLEAR, 0);
		chk(pul[2:0], 3'h7);
		bus(0, tvr_pkg::OFS_EV_COUNT, 0);
		chk(rd, 32'h00000000);
	endtask
	task t_table_flash;
		bus(1, tvr_pkg::OFS_COMP_PAGE, 32'h00000005);
		cen <= 1'b1;
		bus(0, 16'h8006, 0);
		chk(rd, 32'h00005f59);
		bus(1, tvr_pkg::OFS_FLASH_SEL, 0);
		chk(csn, 1'b0);
		bus(1, tvr_pkg::OFS_FLASH_DATA, 32'h0000003c);
		chk(frx, 8'h3c);
		bus(0, tvr_pkg::OFS_FLASH_DATA, 0);
		chk(rd, 32'h000000a6);
		bus(1, tvr_pkg::OFS_FLASH_SEL, 32'h00000001);
		chk(csn, 1'b1);
	endtask
	// One event descriptor carries the counter value at its push
	task t_fifo;
		tm <= 1'b1;
		bus(1, tvr_pkg::OFS_SW_TRIG, 0);
		tm <= 1'b0;
		ee <= 1'b1;
		ed <= 1'b1;
		ew <= 16'h0007;
		@(posedge ref_clk_i);
		ed <= 1'b0;
		bus(0, tvr_pkg::OFS_EVF_COUNT, 0);
		chk(rd, 32'h00000001);
		bus(0, tvr_pkg::OFS_EVF_STATUS, 0);
		chk(rd, 32'h00000001);
		bus(0, tvr_pkg::OFS_EVF_DATA, 0);
		chk(rd, 32'h00010007);
		bus(0, tvr_pkg::OFS_EVF_COUNT, 0);
		chk(rd, 32'h00000000);
	endtask
	// Test word push, opcode gating and a read of the reset location
	task t_misc;
		tmd <= 1'b1;
		bus(1, tvr_pkg::OFS_TEST_WORD, 32'h13579bdf);
		chk(pul[7:5], 3'h5);
		tmd <= 1'b0;
		bus(1, tvr_pkg::OFS_MICRO, 32'h00001234);
		chk(pul[6], 1'b0);
		ok <= 1'b1;
		bus(0, tvr_pkg::OFS_HANDSHAKE, 0);
		chk(rd, 32'h00000003);
		bus(1, tvr_pkg::OFS_MICRO, 32'h00001234);
		chk(pul[6], 1'b1);
		bus(0, tvr_pkg::OFS_MOD_RESET, 0);
		chk(pul[4], 1'b1);
	endtask
	initial
	begin
		ref_clk_i = 0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// Whole run is under two hundred cycles; this cuts a hang
	initial
	begin
		#200000;
		n_mismatch++;
		end_of_test;
	end
	initial
	begin
		nrst_i = 0;
		repeat (10) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		t_defaults;
		t_scratch;
		t_level;
		t_trigger;
		t_table_flash;
		t_fifo;
		t_misc;
		end_of_test;
	end
endmodule
